// ### design/lsd_map.svh
// Constants of the serial LED sink front end
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH

`define LSD_NCH        16
`define LSD_AW         4
`define LSD_DW         16
`define LSD_TAP        8

`define LSD_OFF_STATUS 4'h0
`define LSD_OFF_CLEAR  4'h1
`define LSD_OFF_ENABLE 4'h2
`define LSD_OFF_DATA   4'h3
`define LSD_OFF_OT     4'h4
`define LSD_OFF_OPEN   4'h5
`define LSD_OFF_SHORT  4'h6
`define LSD_OFF_MODE   4'h7

`define LSD_ST_LOAD    0
`define LSD_ST_GFAULT  1
`define LSD_ST_STEP    2
`define LSD_ST_OT      3
`define LSD_ST_W       4

`define LSD_RST_ENABLE 4'h0
`define LSD_RST_CHAN   16'h0000

`endif

// ### design/lsd_pkg.sv
// Types of the serial LED sink front end
package lsd_pkg;

  typedef enum logic [2:0] {
    m_normal,
    m_global,
    m_overtemp,
    m_open,
    m_short,
    m_lowcur
  } lsd_mode_e;

  typedef logic [15:0] lsd_chan_t;

endpackage : lsd_pkg

// ### design/lsd_top.sv
// Serial shift, display latch and diagnostics of a 16-sink LED driver
// Operation
// - Serial clock rise samples input, shifts chain
// - Error mode: serial clock rise steps function
// - Active-low gate switches all sinks always
// - Serial out lags input 8.5 clock cycles
// - Global mode: serial out low for fault
// - Capture global fault at load, keep details
// - Separate data register drives 16 channels
// - Low-current diagnostic mode reduces test current
// - Channel pins sense faults during diagnostics
`timescale 1ns/1ps
`default_nettype none
`include "lsd_map.svh"

module lsd_top (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_nrst,
  input  wire logic                  i_serial_clk,
  input  wire logic                  i_serial_in,
  input  wire logic                  i_latch_strobe,
  input  wire logic                  i_sink_gate_n,
  input  wire logic                  i_error_mode,
  input  wire logic [`LSD_NCH-1:0]   i_open_sense,
  input  wire logic [`LSD_NCH-1:0]   i_short_sense,
  input  wire logic                  i_overtemp,
  input  wire logic [`LSD_AW-1:0]    i_reg_addr,
  input  wire logic [`LSD_DW-1:0]    i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic      [`LSD_DW-1:0]    o_reg_rdata,
  output logic                       o_serial_out,
  output logic      [`LSD_NCH-1:0]   o_channel_sinks,
  output logic                       o_sense_enable,
  output logic                       o_low_current,
  output logic                       o_irq
);

  function automatic logic hit(input logic [`LSD_AW-1:0] a,
                               input logic [`LSD_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Two-flop synchronisers; the first stage feeds only the second
  localparam int NS = 5 + 2 * `LSD_NCH;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  logic [NS-1:0] pins;

  assign pins = {i_short_sense, i_open_sense, i_overtemp,
                 i_error_mode, i_sink_gate_n, i_latch_strobe,
                 i_serial_in};

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // Serial clock sampled like any other pin
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_s3_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
    end else begin
      sclk_s1_reg <= i_serial_clk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
    end
  end

  wire                sin_s    = sync2_reg[0];
  wire                latch_s  = sync2_reg[1];
  wire                gate_s   = sync2_reg[2];
  wire                err_s    = sync2_reg[3];
  wire                ot_s     = sync2_reg[4];
  wire [`LSD_NCH-1:0] open_s   = sync2_reg[5 +: `LSD_NCH];
  wire [`LSD_NCH-1:0] short_s  = sync2_reg[5+`LSD_NCH +: `LSD_NCH];
  wire                clk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire                clk_fall = ~sclk_s2_reg & sclk_s3_reg;

  logic latch_d_reg;
  wire  latch_rise = latch_s & ~latch_d_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) latch_d_reg <= 1'b0;
    else         latch_d_reg <= latch_s;
  end

  // Mode sequencer
  lsd_pkg::lsd_mode_e mode_reg;
  lsd_pkg::lsd_mode_e mode_next;
  lsd_pkg::lsd_mode_e step_mode;

  always_comb begin
    case (mode_reg)
      lsd_pkg::m_global:   step_mode = lsd_pkg::m_overtemp;
      lsd_pkg::m_overtemp: step_mode = lsd_pkg::m_open;
      lsd_pkg::m_open:     step_mode = lsd_pkg::m_short;
      lsd_pkg::m_short:    step_mode = lsd_pkg::m_lowcur;
      lsd_pkg::m_lowcur:   step_mode = lsd_pkg::m_global;
      default:             step_mode = lsd_pkg::m_global;
    endcase
  end

  wire in_diag = (mode_reg != lsd_pkg::m_normal);
  wire step    = in_diag & err_s & clk_rise;

  always_comb begin
    if (!err_s)
      mode_next = lsd_pkg::m_normal;
    else if (!in_diag)
      mode_next = lsd_pkg::m_global;
    else if (clk_rise)
      mode_next = step_mode;
    else
      mode_next = mode_reg;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) mode_reg <= lsd_pkg::m_normal;
    else         mode_reg <= mode_next;
  end

  // Shift, data and diagnostic registers
  lsd_pkg::lsd_chan_t shift_reg;
  lsd_pkg::lsd_chan_t shift_next;
  lsd_pkg::lsd_chan_t data_reg;
  lsd_pkg::lsd_chan_t ot_reg;
  lsd_pkg::lsd_chan_t open_reg;
  lsd_pkg::lsd_chan_t short_reg;
  lsd_pkg::lsd_chan_t open_hit;
  lsd_pkg::lsd_chan_t short_hit;
  logic               gfault_reg;

  // Open and short faults count only where the channel is lit; overtemp counts whatever is lit
  genvar g;
  generate
    for (g = 0; g < `LSD_NCH; g = g + 1) begin : g_chan
      assign open_hit[g]  = data_reg[g] & open_s[g];
      assign short_hit[g] = data_reg[g] & short_s[g];
    end
  endgenerate

  wire                ot_any    = ot_s;
  lsd_pkg::lsd_chan_t ot_hit;
  assign ot_hit = ot_any ? data_reg : `LSD_RST_CHAN;

  wire fault_any = (|open_hit) | (|short_hit) | ot_any;
  wire enter_ot  = step & (step_mode == lsd_pkg::m_overtemp);
  wire enter_op  = step & (step_mode == lsd_pkg::m_open);
  wire enter_sh  = step & (step_mode == lsd_pkg::m_short);

  // Entering a detail step parks its result in the chain for read-back
  always_comb begin
    if (enter_ot)
      shift_next = ot_hit;
    else if (enter_op)
      shift_next = open_hit;
    else if (enter_sh)
      shift_next = short_hit;
    else if (clk_rise && !in_diag)
      shift_next = {shift_reg[`LSD_NCH-2:0], sin_s};
    else
      shift_next = shift_reg;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) shift_reg <= `LSD_RST_CHAN;
    else         shift_reg <= shift_next;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      data_reg   <= `LSD_RST_CHAN;
      gfault_reg <= 1'b0;
    end else if (latch_rise) begin
      data_reg   <= shift_reg;
      gfault_reg <= fault_any;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ot_reg    <= `LSD_RST_CHAN;
      open_reg  <= `LSD_RST_CHAN;
      short_reg <= `LSD_RST_CHAN;
    end else begin
      if (enter_ot) ot_reg    <= ot_hit;
      if (enter_op) open_reg  <= open_hit;
      if (enter_sh) short_reg <= short_hit;
    end
  end

  // Pin-facing outputs
  logic               so_reg;
  lsd_pkg::lsd_chan_t sinks_reg;
  logic               sense_reg;
  logic               lowcur_reg;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst)
      so_reg <= 1'b1;
    else if (mode_reg == lsd_pkg::m_global)
      so_reg <= ~gfault_reg;
    else if (clk_fall)
      so_reg <= shift_reg[`LSD_TAP];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sinks_reg  <= `LSD_RST_CHAN;
      sense_reg  <= 1'b0;
      lowcur_reg <= 1'b0;
    end else begin
      sinks_reg  <= data_reg & {`LSD_NCH{~gate_s}};
      sense_reg  <= in_diag;
      lowcur_reg <= (mode_reg == lsd_pkg::m_lowcur);
    end
  end

  assign o_serial_out    = so_reg;
  assign o_channel_sinks = sinks_reg;
  assign o_sense_enable  = sense_reg;
  assign o_low_current   = lowcur_reg;

  // Register port and interrupt
  logic [`LSD_ST_W-1:0] status_reg;
  logic [`LSD_ST_W-1:0] status_next;
  logic [`LSD_ST_W-1:0] enable_reg;
  logic [`LSD_ST_W-1:0] events;
  logic [`LSD_ST_W-1:0] clr;
  logic [`LSD_DW-1:0]   rdata_next;
  logic [`LSD_DW-1:0]   rdata_reg;
  logic                 irq_reg;

  assign events[`LSD_ST_LOAD]   = latch_rise;
  assign events[`LSD_ST_GFAULT] = latch_rise & fault_any;
  assign events[`LSD_ST_STEP]   = step;
  assign events[`LSD_ST_OT]     = ot_any & in_diag;

  wire wr_clr = i_reg_wr & hit(i_reg_addr, `LSD_OFF_CLEAR);
  wire wr_en  = i_reg_wr & hit(i_reg_addr, `LSD_OFF_ENABLE);

  assign clr = wr_clr ? i_reg_wdata[`LSD_ST_W-1:0] : '0;
  // Set beats clear in the same cycle
  assign status_next = (status_reg & ~clr) | events;

  always_comb begin
    case (i_reg_addr)
      `LSD_OFF_STATUS: rdata_next = {12'h000, status_reg};
      `LSD_OFF_ENABLE: rdata_next = {12'h000, enable_reg};
      `LSD_OFF_DATA:   rdata_next = data_reg;
      `LSD_OFF_OT:     rdata_next = ot_reg;
      `LSD_OFF_OPEN:   rdata_next = open_reg;
      `LSD_OFF_SHORT:  rdata_next = short_reg;
      `LSD_OFF_MODE:   rdata_next = {13'h0000, mode_reg};
      default:         rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      status_reg <= '0;
      enable_reg <= `LSD_RST_ENABLE;
      irq_reg    <= 1'b0;
      rdata_reg  <= 16'h0000;
    end else begin
      status_reg <= status_next;
      if (wr_en) enable_reg <= i_reg_wdata[`LSD_ST_W-1:0];
      irq_reg    <= |(status_reg & enable_reg);
      rdata_reg  <= i_reg_rd ? rdata_next : 16'h0000;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_irq       = irq_reg;

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  a_gate_off_sinks: assert property (
    gate_s |=> o_channel_sinks == 16'h0000)
    else $error("sinks lit while gate high");

  a_sinks_follow_data: assert property (
    !gate_s |=> o_channel_sinks == $past(data_reg))
    else $error("sinks differ from data");

  a_latch_copy_shift: assert property (
    latch_rise |=> data_reg == $past(shift_reg))
    else $error("load did not copy chain");

  a_shift_sample_in: assert property (
    clk_rise && !in_diag |=> shift_reg[0] == $past(sin_s))
    else $error("input bit not sampled");

  a_error_step_mode: assert property (
    step |=> mode_reg != $past(mode_reg) && mode_reg != lsd_pkg::m_normal)
    else $error("error mode did not step");

  a_global_out_level: assert property (
    mode_reg == lsd_pkg::m_global |=> o_serial_out == !$past(gfault_reg))
    else $error("global fault level wrong");

  a_tap_out_delay: assert property (
    clk_fall && mode_reg == lsd_pkg::m_normal
      |=> o_serial_out == $past(shift_reg[`LSD_TAP]))
    else $error("serial out tap wrong");

  a_gfault_at_load: assert property (
    latch_rise |=> gfault_reg == $past(fault_any))
    else $error("global fault not captured");

  a_lowcur_mode_out: assert property (
    mode_reg == lsd_pkg::m_lowcur |=> o_low_current)
    else $error("low current not driven");

  a_lowcur_only_step: assert property (
    mode_reg != lsd_pkg::m_lowcur |=> !o_low_current)
    else $error("low current outside its step");

  a_sense_in_diag: assert property (
    in_diag |=> o_sense_enable)
    else $error("sense not enabled");

  a_sense_off_normal: assert property (
    !in_diag |=> !o_sense_enable)
    else $error("sense left enabled");

  a_open_park_chain: assert property (
    enter_op |=> open_reg == $past(open_hit)
      && shift_reg == $past(open_hit))
    else $error("open result not parked");

endmodule : lsd_top

`default_nettype wire

// ### testbench/lsd_host_model.sv
// Host side of the serial chain: clock, data and load strobe
`timescale 1ns/1ps
`default_nettype none

module lsd_host_model (
  input  wire logic i_clk,
  output logic      o_sclk,
  output logic      o_sdat,
  output logic      o_load,
  input  wire logic i_sout
);
  initial begin
    o_sclk = 1'b0;
    o_sdat = 1'b0;
    o_load = 1'b0;
  end

  // First bit ends in bit 15; 80 ns per bit, sampled mid high phase
  task automatic xfer(input logic [15:0] d, output logic [15:0] q);
    for (int i = 15; i >= 0; i--) begin
      @(posedge i_clk);
      o_sdat <= d[i];
      repeat (2) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1 q[i] = i_sout;
      repeat (2) @(posedge i_clk);
      o_sclk <= 1'b0;
      @(posedge i_clk);
    end
    // Idle line must not keep the last bit
    @(posedge i_clk);
    o_sdat <= ~d[0];
  endtask : xfer

  task automatic tick();
    @(posedge i_clk);
    o_sclk <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_sclk <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : tick

  // Raised only after a whole frame went in
  task automatic load();
    @(posedge i_clk);
    o_load <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_load <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : load
endmodule : lsd_host_model
`default_nettype wire

// ### testbench/lsd_top_test.sv
// Self-checking bench of the LED sink front end
`timescale 1ns/1ps
`default_nettype none
`include "lsd_map.svh"

module lsd_top_test;
  logic        i_core_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        emode = 1'b0, gate_n = 1'b0, ot = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, gf;
  logic [3:0]  addr = 4'h0;
  logic [15:0] opn = '0, sht = '0, wdata = '0, rdata, sinks, q, d1, d2;
  logic [15:0] dp = '0;
  logic        sclk, sdat, load, sout, sense, lowc, irq;
  int          n_fail = 0, compares = 0, cyc = 0;

  always #5 i_core_clk = ~i_core_clk;

  lsd_host_model i_host (.i_clk(i_core_clk), .o_sclk(sclk), .o_sdat(sdat),
    .o_load(load), .i_sout(sout));

  lsd_top i_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_serial_clk(sclk), .i_serial_in(sdat), .i_latch_strobe(load),
    .i_sink_gate_n(gate_n), .i_error_mode(emode), .i_open_sense(opn),
    .i_short_sense(sht), .i_overtemp(ot), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(rdata), .o_serial_out(sout), .o_channel_sinks(sinks),
    .o_sense_enable(sense), .o_low_current(lowc), .o_irq(irq));

  task automatic conclude();
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : wt

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_core_clk);
    addr <= a;
    wdata <= v;
    reg_wr <= 1'b1;
    @(posedge i_core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_core_clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_core_clk);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // Chain output lags input by eight and a half serial clocks
  function automatic logic [15:0] lag(input logic [15:0] a, b);
    logic [31:0] s;
    s = {a, b};
    return s[24:9];
  endfunction : lag

  initial begin
    void'($urandom(79464));
    repeat (16) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    wt(4);
    chk(sinks, 16'h0000, "sinks at reset");
    rd(`LSD_OFF_STATUS, q);
    chk(q, 16'h0000, "status at reset");
    rd(4'hB, q);
    chk(q, 16'h0000, "unmapped read");
    wr(`LSD_OFF_ENABLE, 16'h000F);
    for (int k = 0; k < 4; k++) begin
      d1 = (k == 0) ? 16'h8001 : 16'($urandom);
      d2 = (k == 0) ? 16'hFFFF : 16'($urandom);
      wr(`LSD_OFF_CLEAR, 16'h000F);
      opn <= k[0] ? (16'($urandom) | d2[15:0] & 16'h0001) : 16'h0000;
      sht <= 16'($urandom) & ~d2;
      gate_n <= k[1];
      wt(6);
      // Faults are sensed against the pattern still lit at the strobe
      gf = |(dp & (opn | sht));
      i_host.xfer(d1, q);
      i_host.xfer(d2, q);
      chk(q, lag(d1, d2), "chain output");
      i_host.load();
      wt(8);
      chk(sinks, k[1] ? 16'h0000 : d2, "sinks");
      rd(`LSD_OFF_DATA, q);
      chk(q, d2, "displayed data");
      dp = d2;
      rd(`LSD_OFF_STATUS, q);
      chk(q & 16'h0003, {14'h0, gf, 1'b1}, "load status");
      chk(16'(irq), 16'h0001, "irq raised");
      wr(`LSD_OFF_ENABLE, 16'h0000);
      wt(3);
      chk(16'(irq), 16'h0000, "irq masked");
      wr(`LSD_OFF_ENABLE, 16'h000F);
      wr(`LSD_OFF_CLEAR, 16'h000F);
      wt(3);
      chk(16'(irq), 16'h0000, "irq cleared");
    end
    @(posedge i_core_clk);
    gate_n <= 1'b0;
    emode <= 1'b1;
    sht <= 16'($urandom);
    wt(8);
    rd(`LSD_OFF_MODE, q);
    chk(q, 16'h0001, "global mode");
    chk(16'(sout), 16'(!gf), "global fault flag");
    chk(16'(sense), 16'h0001, "sense enabled");
    @(posedge i_core_clk);
    ot <= 1'b1;
    for (int m = 2; m <= 6; m++) begin
      i_host.tick();
      wt(6);
      rd(`LSD_OFF_MODE, q);
      chk(q, (m == 6) ? 16'h0001 : 16'(m), "mode step");
      chk(16'(lowc), 16'(m == 5), "low current");
    end
    rd(`LSD_OFF_OT, q);
    chk(q, d2, "overtemp detail");
    rd(`LSD_OFF_OPEN, q);
    chk(q, opn & d2, "open detail");
    rd(`LSD_OFF_SHORT, q);
    chk(q, sht & d2, "short detail");
    rd(`LSD_OFF_STATUS, q);
    chk(q, 16'h000C, "diag status");
    chk(16'(irq), 16'h0001, "irq from diag");
    @(posedge i_core_clk);
    emode <= 1'b0;
    wt(8);
    rd(`LSD_OFF_MODE, q);
    chk(q, 16'h0000, "normal mode");
    chk(16'(sense), 16'h0000, "sense off");
    conclude();
  end
endmodule : lsd_top_test
`default_nettype wire
